/* File: dcc_top.sv */
// dual comparator control: mode, routing, result bits, change flag and bus slave
//
// Register access over Wishbone was left to the implementer.
`default_nettype none

// Summary of operation
// - result is high when positive input exceeds negative input, else low
// - mode 010 puts the internal reference on both positive inputs
// - result bits in config bits 7:6 are read-only; writes ignored
// - modes 110 and 001 route unsynchronised results to the two pins
// - port direction bits still enable the routed comparator pins
// - port data read returns zero for every analog input pin
// - flag bit 6 of peripheral flags sets when either result changes
// - flag clears only by writing zero; writing one sets it
// - request needs flag, comparator, peripheral and global enables all set
// - change during a config read still sets the flag
// - any config access copies current results, ending the mismatch
// - while copy differs from results, the flag keeps being set
// - active comparators run in sleep; enabled flag wakes the device
// - mode 111 switches both comparators off
// - waking from sleep leaves the config register unchanged
// - reset clears config to zero: reset mode, all shared pins analog
// - comparators stay powered down while reset is asserted
// - each comparator has an invert bit inverting its reported result

module dcc_top (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [9:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_w,
	output logic      [31:0] wb_dat_r,
	output logic             wb_ack,
	input  wire logic [1:0]  cmp_raw,
	input  wire logic [7:0]  pin_in,
	output logic      [7:0]  pin_out,
	output logic      [7:0]  pin_oe,
	output logic             cmp_power_en,
	output logic             vref_to_pos,
	output logic             input_switch_bit,
	output logic      [1:0]  invert_bits,
	output logic             irq_req,
	output logic             wake_req
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_q_r;
	logic       rst_sync_n;

	// asserts at once, releases two edges later
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_q_r <= 2'h0;
		end else begin
			rst_q_r <= {rst_q_r[0], 1'b1};
		end
	end

	assign rst_sync_n = rst_q_r[1];

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] cmp_sync;
	logic [7:0] pin_sync;

	// raw comparator levels into the clock domain
	dcc_sync #(
		.WIDTH (2)
	) u_cmp_sync (
		.clk_sys    (clk_sys),
		.rst_sync_n (rst_sync_n),
		.async_in   (cmp_raw),
		.sync_out   (cmp_sync)
	);

	// port pins for data reads
	dcc_sync #(
		.WIDTH (8)
	) u_pin_sync (
		.clk_sys    (clk_sys),
		.rst_sync_n (rst_sync_n),
		.async_in   (pin_in),
		.sync_out   (pin_sync)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dcc_pkg::dcc_state_s st_r;
	dcc_pkg::dcc_state_s st_nxt;

	logic [7:0] idx;
	logic       req;
	logic       wr;
	logic [7:0] wdat;
	logic [2:0] mode_nxt;
	logic [1:0] invert;
	logic [1:0] live;
	logic       mismatch;
	logic [7:0] analog;
	logic [7:0] rd_val;

	// pins of port a that read as analog in the given mode
	function automatic logic [7:0] dcc_analog_pins(input logic [2:0] mode);
		logic [7:0] mask;
		mask = dcc_pkg::ANALOG_PINS;
		if (mode == dcc_pkg::MODE_OFF) begin
			mask = 8'h00;
		end
		return mask;
	endfunction : dcc_analog_pins

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------

	// bus decode, register writes, flag and derived outputs
	always_comb begin
		st_nxt = st_r;
		idx    = wb_adr[9:2];
		wdat   = wb_dat_w[7:0];
		req    = wb_cyc && wb_stb && (st_r.bus == dcc_pkg::DCC_BUS_IDLE);
		wr     = req && wb_we && wb_sel[0];

		// results as seen by software, with inversion applied
		invert = {st_r.cmp_cfg[dcc_pkg::BIT_SECOND_INV],
			st_r.cmp_cfg[dcc_pkg::BIT_FIRST_INV]};
		live     = cmp_sync ^ invert;
		mismatch = (live != st_r.result_copy);

		// analog pins read as zero
		analog = dcc_analog_pins(st_r.cmp_cfg[2:0]);
		rd_val = 8'h00;

		// classic single-cycle handshake: ack one cycle, then idle
		unique case (st_r.bus)
			dcc_pkg::DCC_BUS_IDLE: begin
				if (req) begin
					st_nxt.bus = dcc_pkg::DCC_BUS_ACK;
				end
			end
			dcc_pkg::DCC_BUS_ACK: begin
				st_nxt.bus   = dcc_pkg::DCC_BUS_IDLE;
				st_nxt.rdata = 8'h00; // read data stands only with ack
			end
			default: begin
				st_nxt.bus = dcc_pkg::DCC_BUS_IDLE;
			end
		endcase

		// read multiplexer, unmapped reads give zero
		unique case (idx)
			dcc_pkg::IDX_PORT_DATA: begin
				rd_val = pin_sync & ~analog;
			end
			dcc_pkg::IDX_INT_CTRL: begin
				rd_val = st_r.int_ctrl;
			end
			dcc_pkg::IDX_PERIPH_FLAG: begin
				rd_val = st_r.periph_flag;
			end
			dcc_pkg::IDX_CMP_CONFIG: begin
				rd_val = {live, st_r.cmp_cfg};
			end
			dcc_pkg::IDX_PORT_DIR: begin
				rd_val = st_r.port_dir;
			end
			dcc_pkg::IDX_PERIPH_EN: begin
				rd_val = st_r.periph_en;
			end
			default: begin
				rd_val = 8'h00;
			end
		endcase
		if (req) begin
			st_nxt.rdata = wb_we ? 8'h00 : rd_val;
		end

		// register writes, taken with the request
		if (wr) begin
			unique case (idx)
				dcc_pkg::IDX_PORT_DATA: begin
					st_nxt.port_latch = wdat;
				end
				dcc_pkg::IDX_INT_CTRL: begin
					st_nxt.int_ctrl = wdat;
				end
				dcc_pkg::IDX_PERIPH_FLAG: begin
					// zero clears, one sets
					st_nxt.periph_flag = wdat & dcc_pkg::PERIPH_MASK;
				end
				dcc_pkg::IDX_CMP_CONFIG: begin
					// result bits 7:6 are not stored
					st_nxt.cmp_cfg = wdat[5:0];
				end
				dcc_pkg::IDX_PORT_DIR: begin
					st_nxt.port_dir = wdat;
				end
				dcc_pkg::IDX_PERIPH_EN: begin
					st_nxt.periph_en = wdat & dcc_pkg::PERIPH_MASK;
				end
				default: begin
					st_nxt.rdata = 8'h00;
				end
			endcase
		end

		// any access to config takes a fresh copy of the results;
		// a change landing on that edge still sets the flag from the old copy
		if (req && (idx == dcc_pkg::IDX_CMP_CONFIG)) begin
			st_nxt.result_copy = live;
		end

		// mismatch keeps setting the flag, winning over a clear
		if (mismatch) begin
			st_nxt.periph_flag[dcc_pkg::BIT_CMP_IRQ_FLAG] = 1'b1;
		end

		// request needs all three enables; flag is set regardless
		st_nxt.irq = st_nxt.periph_flag[dcc_pkg::BIT_CMP_IRQ_FLAG]
			&& st_nxt.periph_en[dcc_pkg::BIT_CMP_IRQ_EN]
			&& st_nxt.int_ctrl[dcc_pkg::BIT_PERIPH_IRQ_EN]
			&& st_nxt.int_ctrl[dcc_pkg::BIT_GLOBAL_IRQ_EN];

		// wake from sleep only needs the comparator enable
		st_nxt.wake = st_nxt.periph_flag[dcc_pkg::BIT_CMP_IRQ_FLAG]
			&& st_nxt.periph_en[dcc_pkg::BIT_CMP_IRQ_EN];

		// comparator power follows mode, independent of sleep
		mode_nxt = st_nxt.cmp_cfg[2:0];
		st_nxt.cmp_power = (mode_nxt != dcc_pkg::MODE_OFF);

		// internal reference onto both positive inputs
		st_nxt.vref_pos = (mode_nxt == dcc_pkg::MODE_VREF);

		// input switch copied out for the analog muxes
		st_nxt.input_switch = st_nxt.cmp_cfg[dcc_pkg::BIT_INPUT_SWITCH];

		// direction bit low means pin driven, also when routed
		st_nxt.pin_oe = ~st_nxt.port_dir;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------

	// reset holds config at zero and the comparators powered down;
	// there is no sleep input, so sleep and wake never touch state
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_r.bus          <= dcc_pkg::DCC_BUS_IDLE;
			st_r.rdata        <= 8'h00;
			st_r.int_ctrl     <= dcc_pkg::RST_INT_CTRL;
			st_r.periph_flag  <= dcc_pkg::RST_PERIPH_FLAG;
			st_r.periph_en    <= dcc_pkg::RST_PERIPH_EN;
			st_r.port_dir     <= dcc_pkg::RST_PORT_DIR;
			st_r.cmp_cfg      <= dcc_pkg::RST_CMP_CONFIG;
			st_r.port_latch   <= dcc_pkg::RST_PORT_LATCH;
			st_r.result_copy  <= 2'h0;
			st_r.irq          <= 1'b0;
			st_r.wake         <= 1'b0;
			st_r.cmp_power    <= 1'b0;
			st_r.vref_pos     <= 1'b0;
			st_r.input_switch <= 1'b0;
			st_r.pin_oe       <= 8'h00;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic route;
	logic first_drive;
	logic second_drive;

	// bus answer from the state register
	assign wb_ack   = st_r.bus[1];
	assign wb_dat_r = {24'h000000, st_r.rdata};

	// control levels towards the analog side
	assign cmp_power_en     = st_r.cmp_power;
	assign vref_to_pos      = st_r.vref_pos;
	assign input_switch_bit = st_r.input_switch;
	assign invert_bits      = {st_r.cmp_cfg[dcc_pkg::BIT_SECOND_INV],
		st_r.cmp_cfg[dcc_pkg::BIT_FIRST_INV]};
	assign irq_req          = st_r.irq;
	assign wake_req         = st_r.wake;
	assign pin_oe           = st_r.pin_oe;

	// routed pins carry the raw result, deliberately not synchronised
	assign route = (st_r.cmp_cfg[2:0] == dcc_pkg::MODE_ROUTE_A)
		|| (st_r.cmp_cfg[2:0] == dcc_pkg::MODE_ROUTE_B);
	assign first_drive  = cmp_raw[0] ^ st_r.cmp_cfg[dcc_pkg::BIT_FIRST_INV];
	assign second_drive = cmp_raw[1] ^ st_r.cmp_cfg[dcc_pkg::BIT_SECOND_INV];

	// pin data: port latch, with the two comparator pins swapped in while routed
	always_comb begin
		pin_out = st_r.port_latch;
		if (route) begin
			pin_out[dcc_pkg::BIT_FIRST_PIN]  = first_drive;
			pin_out[dcc_pkg::BIT_SECOND_PIN] = second_drive;
		end
	end

endmodule : dcc_top

`default_nettype wire

/* File: dcc_pkg.sv */
// package: register map, field layout, reset values and modes of the comparator control
`default_nettype none

package dcc_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_PORT_DATA   = 8'h05;
	localparam logic [7:0] IDX_INT_CTRL    = 8'h0b;
	localparam logic [7:0] IDX_PERIPH_FLAG = 8'h0c;
	localparam logic [7:0] IDX_CMP_CONFIG  = 8'h1f;
	localparam logic [7:0] IDX_PORT_DIR    = 8'h85;
	localparam logic [7:0] IDX_PERIPH_EN   = 8'h8c;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_GLOBAL_IRQ_EN = 7;
	localparam int BIT_PERIPH_IRQ_EN = 6;
	localparam int BIT_CMP_IRQ_FLAG  = 6;
	localparam int BIT_CMP_IRQ_EN    = 6;
	localparam int BIT_SECOND_INV    = 5;
	localparam int BIT_FIRST_INV     = 4;
	localparam int BIT_INPUT_SWITCH  = 3;
	localparam int BIT_FIRST_PIN     = 3;
	localparam int BIT_SECOND_PIN    = 4;

	// implemented bits of the flag and enable registers
	localparam logic [7:0] PERIPH_MASK = 8'hf7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_INT_CTRL    = 8'h00;
	localparam logic [7:0] RST_PERIPH_FLAG = 8'h00;
	localparam logic [5:0] RST_CMP_CONFIG  = 6'h00;
	localparam logic [7:0] RST_PORT_DIR    = 8'hff;
	localparam logic [7:0] RST_PERIPH_EN   = 8'h00;
	localparam logic [7:0] RST_PORT_LATCH  = 8'h00;

	// ----------------------------------------------------------------
	// comparator modes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_RESET   = 3'h0;
	localparam logic [2:0] MODE_ROUTE_A = 3'h1;
	localparam logic [2:0] MODE_VREF    = 3'h2;
	localparam logic [2:0] MODE_ROUTE_B = 3'h6;
	localparam logic [2:0] MODE_OFF     = 3'h7;

	// analog pins of port a while comparators are in use
	localparam logic [7:0] ANALOG_PINS = 8'h0f;

	// ----------------------------------------------------------------
	// bus state and register state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DCC_BUS_IDLE = 2'b01,
		DCC_BUS_ACK  = 2'b10
	} dcc_bus_e;

	typedef struct packed {
		dcc_bus_e   bus;
		logic [7:0] rdata;
		logic [7:0] int_ctrl;
		logic [7:0] periph_flag;
		logic [7:0] periph_en;
		logic [7:0] port_dir;
		logic [5:0] cmp_cfg;
		logic [7:0] port_latch;
		logic [1:0] result_copy;
		logic       irq;
		logic       wake;
		logic       cmp_power;
		logic       vref_pos;
		logic       input_switch;
		logic [7:0] pin_oe;
	} dcc_state_s;

endpackage : dcc_pkg

`default_nettype wire

/* File: dcc_sync.sv */
// two flip-flop synchroniser for asynchronous levels
`default_nettype none

module dcc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_sync_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

endmodule : dcc_sync

`default_nettype wire

/* File: dcc_top_sva.sv */
// checker: bus timing and configuration outputs of the comparator control
`default_nettype none

module dcc_top_sva (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        wb_cyc,
	input wire logic        wb_stb,
	input wire logic        wb_we,
	input wire logic [9:0]  wb_adr,
	input wire logic [3:0]  wb_sel,
	input wire logic [31:0] wb_dat_w,
	input wire logic [31:0] wb_dat_r,
	input wire logic        wb_ack,
	input wire logic        cmp_power_en,
	input wire logic        vref_to_pos,
	input wire logic        input_switch_bit,
	input wire logic [1:0]  invert_bits,
	input wire logic        irq_req,
	input wire logic        wake_req
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// a config write being taken at this edge
	logic cfg_wr;
	assign cfg_wr = wb_cyc && wb_stb && !wb_ack && wb_we && wb_sel[0]
		&& wb_adr[9:2] == dcc_pkg::IDX_CMP_CONFIG;

	property p_ack_pulse; wb_ack |=> !wb_ack; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_resp; wb_cyc && wb_stb && !wb_ack |=> wb_ack; endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("request not acked next cycle");
	property p_rd_idle; !wb_ack |-> wb_dat_r == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside ack");
	property p_rd_upper; wb_ack |-> wb_dat_r[31:8] == 24'h0; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read data not zero");
	property p_irq_wake; irq_req |-> wake_req; endproperty
	a_irq_wake: assert property (p_irq_wake) else $error("request without wake");
	property p_vref;
		cfg_wr |=> ##1 vref_to_pos == ($past(wb_dat_w[2:0], 2) == dcc_pkg::MODE_VREF);
	endproperty
	a_vref: assert property (p_vref) else $error("reference select wrong");
	property p_power;
		cfg_wr |=> ##1 cmp_power_en == ($past(wb_dat_w[2:0], 2) != dcc_pkg::MODE_OFF);
	endproperty
	a_power: assert property (p_power) else $error("comparator power wrong");
	property p_inv; cfg_wr |=> ##1 invert_bits == $past(wb_dat_w[5:4], 2); endproperty
	a_inv: assert property (p_inv) else $error("invert bits wrong");
	property p_switch; cfg_wr |=> ##1 input_switch_bit == $past(wb_dat_w[3], 2); endproperty
	a_switch: assert property (p_switch) else $error("input switch wrong");
endmodule : dcc_top_sva

`default_nettype wire

/* File: dcc_model.sv */
// partner: behavioural comparator pair and port pins with pull-ups
`default_nettype none

module dcc_model (
	input  wire logic [7:0] vpos_a,
	input  wire logic [7:0] vneg_a,
	input  wire logic [7:0] vpos_b,
	input  wire logic [7:0] vneg_b,
	input  wire logic [7:0] vref_level,
	input  wire logic       vref_to_pos,
	input  wire logic       cmp_power_en,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	output logic      [1:0] cmp_raw,
	output logic      [7:0] pin_in
);
	// compare levels; reference on positive inputs when selected; dead when unpowered
	always_comb begin
		cmp_raw[0] = cmp_power_en && ((vref_to_pos ? vref_level : vpos_a) > vneg_a);
		cmp_raw[1] = cmp_power_en && ((vref_to_pos ? vref_level : vpos_b) > vneg_b);
		pin_in     = (pin_out & pin_oe) | ~pin_oe; // undriven pins pulled up
	end
endmodule : dcc_model

`default_nettype wire

/* File: dcc_top_bench.sv */
// testbench: register, flag, routing and power scenarios of the comparator control
`default_nettype none

module dcc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [9:0]  wb_adr = 10'h000;
	logic [31:0] wb_dat_w = 32'h0;
	logic [31:0] wb_dat_r;
	logic        wb_ack;
	logic [1:0]  cmp_raw;
	logic [7:0]  pin_in, pin_out, pin_oe;
	logic        cmp_power_en, vref_to_pos, irq_req, wake_req;
	logic [7:0]  vpos_a = 8'h10, vneg_a = 8'h20, vpos_b = 8'h10, vneg_b = 8'h20;
	int          mismatches = 0;
	int          cmp_count = 0;

	always #12.5 clk_sys = ~clk_sys;

	dcc_top i_dcc_top (.clk_sys, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel(4'h1),
		.wb_dat_w, .wb_dat_r, .wb_ack, .cmp_raw, .pin_in, .pin_out, .pin_oe, .cmp_power_en,
		.vref_to_pos, .input_switch_bit(), .invert_bits(), .irq_req, .wake_req);
	dcc_model i_dcc_model (.vpos_a, .vneg_a, .vpos_b, .vneg_b, .vref_level(8'h80),
		.vref_to_pos, .cmp_power_en, .pin_out, .pin_oe, .cmp_raw, .pin_in);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one classic cycle, released at the ack edge
	task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_dat_w <= {24'h0, wd};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20) chk(32'h0, 32'h1);
		rd = wb_dat_r[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [7:0] d;
		bus(1'b1, idx, wd, d);
		repeat (2) @(posedge clk_sys);
	endtask : wr

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		bus(1'b0, idx, 8'h00, d);
		chk({24'h0, d}, {24'h0, exp});
	endtask : rdc

	task automatic t_reset;
		rdc(dcc_pkg::IDX_CMP_CONFIG, 8'h00);
		rdc(dcc_pkg::IDX_PORT_DIR, 8'hff);
		rdc(dcc_pkg::IDX_INT_CTRL, 8'h00);
		rdc(dcc_pkg::IDX_PERIPH_FLAG, 8'h00);
		rdc(dcc_pkg::IDX_PERIPH_EN, 8'h00);
		rdc(8'h40, 8'h00);
		chk({24'h0, pin_oe}, 32'h0);
	endtask : t_reset

	task automatic t_flag;
		wr(dcc_pkg::IDX_PERIPH_FLAG, 8'h00);
		@(posedge clk_sys);
		vneg_a <= 8'h00;
		repeat (4) @(posedge clk_sys);
		rdc(dcc_pkg::IDX_PERIPH_FLAG, 8'h40);
		wr(dcc_pkg::IDX_PERIPH_FLAG, 8'h00);
		rdc(dcc_pkg::IDX_PERIPH_FLAG, 8'h40);
		rdc(dcc_pkg::IDX_CMP_CONFIG, 8'h40);
		wr(dcc_pkg::IDX_PERIPH_FLAG, 8'h00);
		rdc(dcc_pkg::IDX_PERIPH_FLAG, 8'h00);
		wr(dcc_pkg::IDX_PERIPH_FLAG, 8'h40);
		rdc(dcc_pkg::IDX_PERIPH_FLAG, 8'h40);
	endtask : t_flag

	task automatic t_irq;
		chk({31'h0, wake_req}, 32'h0);
		wr(dcc_pkg::IDX_PERIPH_EN, 8'h40);
		chk({30'h0, irq_req, wake_req}, 32'h1);
		wr(dcc_pkg::IDX_INT_CTRL, 8'h40);
		chk({31'h0, irq_req}, 32'h0);
		wr(dcc_pkg::IDX_INT_CTRL, 8'hc0);
		chk({31'h0, irq_req}, 32'h1);
		wr(dcc_pkg::IDX_PERIPH_FLAG, 8'h00);
		chk({31'h0, irq_req}, 32'h0);
	endtask : t_irq

	task automatic t_cfg;
		wr(dcc_pkg::IDX_PERIPH_EN, 8'h00);
		wr(dcc_pkg::IDX_CMP_CONFIG, 8'h02);
		chk({31'h0, vref_to_pos}, 32'h1);
		repeat (4) @(posedge clk_sys);
		chk({30'h0, irq_req, wake_req}, 32'h0);
		rdc(dcc_pkg::IDX_CMP_CONFIG, 8'hc2);
		wr(dcc_pkg::IDX_CMP_CONFIG, 8'hfa);
		repeat (4) @(posedge clk_sys);
		rdc(dcc_pkg::IDX_CMP_CONFIG, 8'h3a);
	endtask : t_cfg

	// routed pins per mode: raw result on pins 3/4 only in the two routing modes
	task automatic t_route;
		logic [2:0] md [3] = '{dcc_pkg::MODE_ROUTE_A, dcc_pkg::MODE_ROUTE_B, dcc_pkg::MODE_VREF};
		wr(dcc_pkg::IDX_PORT_DIR, 8'he7);
		chk({24'h0, pin_oe}, 32'h18);
		for (int i = 0; i < 3; i++) begin
			wr(dcc_pkg::IDX_CMP_CONFIG, {5'h00, md[i]});
			chk({30'h0, pin_out[4:3]}, (i < 2) ? 32'h1 : 32'h0);
		end
		rdc(dcc_pkg::IDX_PORT_DATA, 8'he0);
	endtask : t_route

	task automatic t_off;
		wr(dcc_pkg::IDX_CMP_CONFIG, 8'h07);
		chk({30'h0, cmp_power_en, vref_to_pos}, 32'h0);
		wr(dcc_pkg::IDX_PORT_DIR, 8'hff);
		rdc(dcc_pkg::IDX_PORT_DATA, 8'hff);
	endtask : t_off

	task automatic test_done;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// main sequence
	initial begin
		repeat (20) @(posedge clk_sys);
		chk({31'h0, cmp_power_en}, 32'h0);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset();
		t_flag();
		t_irq();
		t_cfg();
		t_route();
		t_off();
		test_done();
	end

	// watchdog
	initial begin
		#(25 * 4000);
		mismatches++;
		test_done();
	end
endmodule : dcc_top_bench

bind dcc_top dcc_top_sva i_dcc_top_sva (.clk_sys, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
	.wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .cmp_power_en, .vref_to_pos, .input_switch_bit,
	.invert_bits, .irq_req, .wake_req);

`default_nettype wire
